/* core/host_pins.v */
/*
 Host-side handshake and strobe logic of a card storage controller's
 16-bit parallel host port: wait/ready stretching, Ultra DMA readiness
 and strobing, write strobe capture and the static indication pins.
 Assumes every host pin is asynchronous to ref_clk and that the inner
 controller supplies busy, transfer-word and burst control levels.
*/
`timescale 1ns/1ps
`include "host_pins_defs.vh"
// Overview of operation
// - Drive wait low to stretch memory/IO cycles.
// - Wait pin serves as ready during Ultra DMA.
// - Data-in ready shows readiness; negated to pause.
// - Device strobe toggles once per outgoing word.
// - Withholding strobe edges pauses data-out burst.
// - Memory mode write strobe captures register data.
// - I/O mode write strobe only for config registers.
// - Write-protect output held low after initialization.
// - IO16 indication low for 16-bit I/O ports.
// - CS16 indication low for word transfers in IDE.
// - Host stop ends the current Ultra DMA burst.
// - Host strobe both edges latch incoming data.
module host_pins #(
    parameter INIT_LEN = `INIT_CYCLES
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        reset,
    // Host pins
    input  wire        ide_sel_n,
    input  wire        pc_io_mode,
    input  wire        we_n,
    input  wire        host_cycle_n,
    input  wire        dmack_n,
    input  wire        stop,
    input  wire        hstrobe,
    input  wire [15:0] host_data,
    output reg         wait_n,
    output reg         dstrobe,
    output reg         io16_n,
    output reg         cs16_n,
    output reg         wp,
    // Inner controller
    input  wire        core_busy,
    input  wire        udma_in_act,
    input  wire        udma_out_act,
    input  wire        rx_ready,
    input  wire        tx_valid,
    input  wire        port16,
    input  wire        word_xfer,
    output reg         mode_ide,
    output reg         mode_io,
    output reg         cfg_wr,
    output reg         reg_wr,
    output reg  [15:0] wr_data,
    output reg         rx_word,
    output reg  [15:0] rx_data,
    output reg         tx_take,
    output reg         burst_end
);

// ------------------------------------------------------------------
// Synchronisers
// ------------------------------------------------------------------
// Data is sampled only after its strobe has crossed, so it is stable.
reg [1:0] ide_s, io_s, we_s, cyc_s, ack_s, stop_s, hs_s;
reg       we_q, hs_q, cyc_q;
always @(posedge ref_clk) begin
    if (reset) begin
        ide_s  <= `SYNC_RST;
        io_s   <= `SYNC_RST;
        we_s   <= {2{`PIN_HIGH}};
        cyc_s  <= {2{`PIN_HIGH}};
        ack_s  <= {2{`PIN_HIGH}};
        stop_s <= `SYNC_RST;
        hs_s   <= `SYNC_RST;
        we_q   <= `PIN_HIGH;
        hs_q   <= `PIN_LOW;
        cyc_q  <= `PIN_HIGH;
    end else begin
        ide_s  <= {ide_s[0], ide_sel_n};
        io_s   <= {io_s[0], pc_io_mode};
        we_s   <= {we_s[0], we_n};
        cyc_s  <= {cyc_s[0], host_cycle_n};
        ack_s  <= {ack_s[0], dmack_n};
        stop_s <= {stop_s[0], stop};
        hs_s   <= {hs_s[0], hstrobe};
        we_q   <= we_s[1];
        hs_q   <= hs_s[1];
        cyc_q  <= cyc_s[1];
    end
end

wire we_rise  = we_s[1] & ~we_q;
wire hs_edge  = hs_s[1] ^ hs_q;
wire idle     = cyc_s[1] & cyc_q & ack_s[1];

// ------------------------------------------------------------------
// Mode selection
// ------------------------------------------------------------------
// The mode only moves while no host cycle or DMA is under way.
reg [1:0] mode_q;
always @(posedge ref_clk) begin
    if (reset) begin
        mode_q <= `MODE_MEM;
    end else if (idle) begin
        if (!ide_s[1]) begin
            mode_q <= `MODE_IDE;
        end else if (io_s[1]) begin
            mode_q <= `MODE_IO;
        end else begin
            mode_q <= `MODE_MEM;
        end
    end
end
wire is_ide = (mode_q == `MODE_IDE);
wire is_io  = (mode_q == `MODE_IO);

// ------------------------------------------------------------------
// Reset initialization
// ------------------------------------------------------------------
// The counter stops at INIT_LEN and stays there until the next reset,
// so the write-protect output can never rise again in normal running.
// A longer sequence only needs a larger INIT_LEN; the width is fixed
// at sixteen bits, which bounds the longest supported sequence.
reg [15:0] init_q;
wire       init_done = (init_q == INIT_LEN[15:0]);
always @(posedge ref_clk) begin
    if (reset) begin
        init_q <= `CNT_RST;
    end else if (!init_done) begin
        init_q <= init_q + `CNT_ONE;
    end
end

// ------------------------------------------------------------------
// Ultra DMA strobing
// ------------------------------------------------------------------
// Data-out edges are spaced at least two cycles apart so that the host
// sees each level long enough; the price is half the peak word rate.
// A host stop blocks both directions at once, at the same edge that sets burst_end.
wire udma    = is_ide & ~ack_s[1];
wire stop_on = udma & stop_s[1];
always @(posedge ref_clk) begin
    if (reset) begin
        dstrobe   <= `PIN_LOW;
        tx_take   <= `PIN_LOW;
        rx_word   <= `PIN_LOW;
        rx_data   <= `WORD_RST;
        burst_end <= `PIN_LOW;
    end else begin
        burst_end <= stop_on & (udma_in_act | udma_out_act);
        tx_take   <= `PIN_LOW;
        rx_word   <= `PIN_LOW;
        // No edge while tx_valid is low: the burst simply pauses.
        if (udma && udma_out_act && tx_valid && !stop_on
            && !tx_take) begin
            dstrobe <= ~dstrobe;
            tx_take <= `PIN_HIGH;
        end
        if (udma && udma_in_act && hs_edge && !stop_on) begin
            rx_word <= `PIN_HIGH;
            rx_data <= host_data;
        end
    end
end

// ------------------------------------------------------------------
// Write strobe capture
// ------------------------------------------------------------------
// Capture is on the rising edge of the write strobe, when the host
// data has been stable for the whole low phase of the strobe.
// In True IDE mode the edge is masked by is_ide, so no write is ever taken.
always @(posedge ref_clk) begin
    if (reset) begin
        cfg_wr  <= `PIN_LOW;
        reg_wr  <= `PIN_LOW;
        wr_data <= `WORD_RST;
    end else begin
        cfg_wr <= `PIN_LOW;
        reg_wr <= `PIN_LOW;
        if (we_rise && !is_ide) begin
            wr_data <= host_data;
            cfg_wr  <= `PIN_HIGH;
            reg_wr  <= ~is_io;
        end
    end
end

// ------------------------------------------------------------------
// Handshake and indication outputs
// ------------------------------------------------------------------
// Every pin here comes straight from a flip-flop, which keeps glitches
// off the host bus at the cost of one cycle of added latency.
always @(posedge ref_clk) begin
    if (reset) begin
        wait_n   <= `PIN_HIGH;
        io16_n   <= `PIN_HIGH;
        cs16_n   <= `PIN_HIGH;
        wp       <= `PIN_HIGH;
        mode_ide <= `PIN_LOW;
        mode_io  <= `PIN_LOW;
    end else begin
        mode_ide <= is_ide;
        mode_io  <= is_io;
        wp       <= ~init_done;
        if (udma) begin
            // The shared pin carries data-in readiness in Ultra DMA.
            wait_n <= ~(udma_in_act & rx_ready & ~stop_on);
        end else if (is_ide) begin
            wait_n <= ~core_busy;
        end else begin
            wait_n <= ~(core_busy & ~cyc_s[1]);
        end
        io16_n <= ~(is_io & port16);
        cs16_n <= ~(is_ide & word_xfer);
    end
end

endmodule

/* core/host_pins_defs.vh */
/*
 Constants for the host handshake pin block: mode codes, pin levels
 and reset values. Included by the design file by bare name.
*/
`ifndef HOST_PINS_DEFS_VH
`define HOST_PINS_DEFS_VH
`define MODE_MEM        2'h0
`define MODE_IO         2'h1
`define MODE_IDE        2'h2
`define PIN_LOW         1'h0
`define PIN_HIGH        1'h1
`define SYNC_RST        2'h0
`define INIT_CYCLES     16'h0010
`define CNT_RST         16'h0000
`define CNT_ONE         16'h0001
`define WORD_RST        16'h0000
`endif

/* verification/host_pins_sva.sv */
/* Port assertions for host_pins. Assumes the bench keeps the host idle
   while it changes mode. */
`timescale 1ns/1ps
module host_pins_sva (
    input wire ref_clk, reset, port16, word_xfer, core_busy, host_cycle_n,
    input wire tx_valid, stop, mode_io, mode_ide, io16_n, cs16_n, cfg_wr,
    input wire reg_wr, wait_n, tx_take, dstrobe, rx_word, wp
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    chk_wp_low: assert property (!wp |=> !wp)
        else $error("wp rose after init");
    chk_io16_low: assert property ((mode_io && port16) [*2] |-> !io16_n)
        else $error("io16_n not low");
    chk_cs16_low: assert property ((mode_ide && word_xfer) [*2] |-> !cs16_n)
        else $error("cs16_n not low");
    chk_ide_we_off: assert property (mode_ide [*5] |-> !cfg_wr && !reg_wr)
        else $error("write taken in ide");
    chk_io_no_reg: assert property (mode_io [*5] |-> !reg_wr)
        else $error("task write in io mode");
    chk_reg_cfg: assert property (reg_wr |-> cfg_wr && !mode_io)
        else $error("bad write pulse");
    chk_wait_held: assert property (
        (!mode_ide && core_busy && !host_cycle_n) [*5] |-> !wait_n)
        else $error("wait_n not low");
    chk_take_edge: assert property (tx_take |-> dstrobe != $past(dstrobe))
        else $error("word sent without edge");
    chk_idle_still: assert property (!tx_valid |=> $stable(dstrobe))
        else $error("edge while paused");
    chk_stop_rx: assert property (stop [*6] |-> !rx_word)
        else $error("word after stop");
endmodule
bind host_pins host_pins_sva chk (
    .ref_clk(ref_clk), .reset(reset), .port16(port16),
    .word_xfer(word_xfer), .core_busy(core_busy),
    .host_cycle_n(host_cycle_n), .tx_valid(tx_valid), .stop(stop),
    .mode_io(mode_io), .mode_ide(mode_ide), .io16_n(io16_n),
    .cs16_n(cs16_n), .cfg_wr(cfg_wr), .reg_wr(reg_wr), .wait_n(wait_n),
    .tx_take(tx_take), .dstrobe(dstrobe), .rx_word(rx_word), .wp(wp));

/* verification/host_side.sv */
/* Host model: write strobe and host data strobe with data bus. */
`timescale 1ns/1ps
module host_side (output logic we_n, output logic hstrobe,
                  output logic [15:0] host_data);
    initial {we_n, hstrobe, host_data} = {2'h2, 16'h0000};
    // Data held past the rising edge, then the bus is driven inverted.
    task automatic wr(input logic [15:0] d);
        host_data = d;
        #100 we_n = 0;
        #300 we_n = 1;
        #250 host_data = ~d;
    endtask
    // One word per strobe edge, edges 200 ns apart.
    task automatic hs(input logic [15:0] d);
        host_data = d;
        #20 hstrobe = ~hstrobe;
        #180 host_data = ~d;
    endtask
endmodule

/* verification/testbench.sv */
/* Bench for host_pins; host_side plays the host, the bench the core. */
`timescale 1ns/1ps
module testbench;
    logic ref_clk, reset, ide_sel_n, pc_io_mode, host_cycle_n, dmack_n, stop;
    logic core_busy, udma_in_act, udma_out_act, rx_ready, tx_valid, port16;
    logic word_xfer, we_n, hstrobe, wait_n, dstrobe, io16_n, cs16_n, wp;
    logic mode_ide, mode_io, cfg_wr, reg_wr, rx_word, tx_take, burst_end;
    logic [15:0] host_data, wr_data, rx_data;
    int n_mismatch, samples_checked, n_cfg, n_reg, n_rx, n_tx, cyc;
    host_pins #(.INIT_LEN(4)) DUT (
        .ref_clk(ref_clk), .reset(reset), .ide_sel_n(ide_sel_n),
        .pc_io_mode(pc_io_mode), .we_n(we_n), .host_cycle_n(host_cycle_n),
        .dmack_n(dmack_n), .stop(stop), .hstrobe(hstrobe),
        .host_data(host_data), .wait_n(wait_n), .dstrobe(dstrobe),
        .io16_n(io16_n), .cs16_n(cs16_n), .wp(wp), .core_busy(core_busy),
        .udma_in_act(udma_in_act), .udma_out_act(udma_out_act),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .port16(port16),
        .word_xfer(word_xfer), .mode_ide(mode_ide), .mode_io(mode_io),
        .cfg_wr(cfg_wr), .reg_wr(reg_wr), .wr_data(wr_data),
        .rx_word(rx_word), .rx_data(rx_data), .tx_take(tx_take),
        .burst_end(burst_end));
    host_side host (.we_n(we_n), .hstrobe(hstrobe), .host_data(host_data));
    initial begin
        ref_clk = 0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        n_cfg += cfg_wr === 1'b1;
        n_reg += reg_wr === 1'b1;
        n_rx += rx_word === 1'b1;
        n_tx += tx_take === 1'b1;
        if (++cyc == 2000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task chk(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task t_mem;
        chk(wp === 1'b1 && io16_n === 1'b1, "reset");
        host_cycle_n = 0; core_busy = 1; step(8);
        chk(wp === 1'b0 && wait_n === 1'b0, "wait");
        core_busy = 0; host_cycle_n = 1; n_cfg = 0; n_reg = 0;
        host.wr(16'hA55A); step(8);
        chk(n_cfg == 1 && n_reg == 1 && wr_data === 16'hA55A, "mem");
    endtask
    task t_io;
        pc_io_mode = 1; port16 = 1; n_cfg = 0; n_reg = 0; step(6);
        chk(mode_io === 1'b1 && io16_n === 1'b0, "io16");
        host.wr(16'h3C0F); step(8);
        chk(n_cfg == 1 && n_reg == 0 && wr_data === 16'h3C0F, "io");
        port16 = 0; pc_io_mode = 0; step(6);
    endtask
    task t_ide;
        ide_sel_n = 0; word_xfer = 1; n_cfg = 0; step(6);
        chk(mode_ide === 1'b1 && cs16_n === 1'b0, "cs16");
        host.wr(16'h1234); step(8);
        chk(n_cfg == 0, "ide write");
        dmack_n = 0; udma_in_act = 1; rx_ready = 1; n_rx = 0; step(5);
        chk(wait_n === 1'b0, "ready");
        host.hs(16'h0F0F); host.hs(16'hF0F0); step(6);
        chk(n_rx == 2 && rx_data === 16'hF0F0, "rx");
        rx_ready = 0; step(2);
        chk(wait_n === 1'b1, "pause");
        rx_ready = 1; stop = 1; n_rx = 0; step(5);
        host.hs(16'h5555); step(6);
        chk(burst_end === 1'b1 && n_rx == 0, "stop");
        stop = 0; udma_in_act = 0; udma_out_act = 1; tx_valid = 1; n_tx = 0;
        step(8);
        chk(n_tx >= 3 && dstrobe === 1'(n_tx % 2), "tx");
        tx_valid = 0; step(1); n_tx = 0; step(5);
        chk(n_tx == 0, "tx pause");
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {reset, ide_sel_n, host_cycle_n, dmack_n, pc_io_mode, stop} = 6'h3C;
        {core_busy, udma_in_act, udma_out_act, rx_ready} = 4'h0;
        {tx_valid, port16, word_xfer, cyc} = 0;
        step(12);
        reset = 0;
        t_mem; t_io; t_ide;
        report_and_stop;
    end
endmodule
